// ---- inc/imh_pkg.sv ----
// constants, carriers and types shared by the imu host register bank
package imh_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] A_DEV_ID = 7'h00;
  localparam logic [6:0] A_REV = 7'h01;
  localparam logic [6:0] A_SIF = 7'h02;
  localparam logic [6:0] A_ACC = 7'h03;
  localparam logic [6:0] A_GYR = 7'h04;
  localparam logic [6:0] A_LPF = 7'h06;
  localparam logic [6:0] A_ENA = 7'h08;
  localparam logic [6:0] A_CMD = 7'h0a;
  localparam logic [6:0] A_FIFO = 7'h17;
  localparam logic [6:0] A_ST_LOCK = 7'h2d;
  localparam logic [6:0] A_ST_DRDY = 7'h2e;
  localparam logic [6:0] A_ST_MOT = 7'h2f;
  localparam logic [6:0] A_TS_L = 7'h30;
  localparam logic [6:0] A_TS_M = 7'h31;
  localparam logic [6:0] A_TS_H = 7'h32;
  localparam logic [6:0] A_OUT_LO = 7'h33;
  localparam logic [6:0] A_OUT_HI = 7'h40;
  localparam logic [6:0] ADDR_STEP = 7'h01;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned SIF_WIRE3 = 7;
  localparam int unsigned SIF_STEP = 6;
  localparam int unsigned SIF_ORDER = 5;
  localparam logic [7:0] SIF_RST = 8'h20;
  localparam int unsigned ENA_ACC = 0;
  localparam int unsigned ENA_GYR = 1;
  localparam int unsigned ENA_FUS = 3;
  localparam int unsigned DRDY_ACC = 0;
  localparam int unsigned DRDY_GYR = 1;
  localparam int unsigned DRDY_FIFO = 2;
  localparam int unsigned LOCK_AVAIL = 0;
  localparam int unsigned LOCK_DONE = 7;
  localparam int unsigned TS_MID_POS = 8;
  localparam int unsigned TS_HI_POS = 16;
  localparam logic [23:0] TS_STEP = 24'h000001;
  localparam logic [23:0] TS_MAX = 24'hffffff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  // ---------------------------------------------------------------
  // serial framing
  // ---------------------------------------------------------------
  localparam int unsigned SPI_RD = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;

  // raw sample set, temperature in the lowest bytes
  typedef struct packed {
    logic [15:0] gz;
    logic [15:0] gy;
    logic [15:0] gx;
    logic [15:0] az;
    logic [15:0] ay;
    logic [15:0] ax;
    logic [15:0] temp;
  } imh_sample_s;

  // one register access carried from the link to the bank
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } imh_req_s;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_DUMMY = 2'b01,
    PH_DATA = 2'b10
  } imh_phase_e;

endpackage

// ---- src/imh_spi_link.sv ----
// serial link engine on the host's serial clock
module imh_spi_link import imh_pkg::*; (
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic link_rst_n,
  input wire logic spi_sdi,
  input wire logic sdio_sense,
  input wire logic wire3,
  input wire logic step_en,
  input wire logic ack_tgl,
  input wire logic [7:0] rdata,
  output logic req_tgl,
  output imh_req_s req,
  output logic sdo_drive,
  output logic sdo_drive_en,
  output logic sdio_drive,
  output logic sdio_drive_en
);

  typedef struct packed {
    logic [1:0] step_sync;
    logic [1:0] wire3_sync;
    logic [1:0] ack_sync;
    imh_phase_e phase;
    logic [2:0] bit_cnt;
    logic [6:0] sh_in;
    logic [7:0] sh_out;
    logic [6:0] addr;
    logic is_rd;
    logic req_tgl;
    imh_req_s req;
  } imh_link_s;

  typedef struct packed {
    logic d;
    logic sdo_en;
    logic sdio_en;
  } imh_pin_s;

  imh_link_s s_r, s_nxt, f;
  imh_pin_s pin_r;
  logic in_frame_r;
  logic din;
  logic [7:0] byte_in;
  logic [6:0] next_addr;

  // address for the following byte of a burst
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic en);
    return en ? a + ADDR_STEP : a;
  endfunction

  // ---------------------------------------------------------------
  // frame decode and request issue
  // ---------------------------------------------------------------
  // the first edge of a frame restarts the byte framing
  always_comb begin
    f = s_r;
    if (!in_frame_r) begin
      f.phase = PH_CMD;
      f.bit_cnt = '0;
      f.sh_out = '0;
      f.is_rd = 1'b0;
    end
    s_nxt = f;
    s_nxt.step_sync = {f.step_sync[0], step_en};
    s_nxt.wire3_sync = {f.wire3_sync[0], wire3};
    s_nxt.ack_sync = {f.ack_sync[0], ack_tgl};
    din = f.wire3_sync[1] ? sdio_sense : spi_sdi;
    byte_in = {f.sh_in, din};
    next_addr = step_addr(f.addr, f.step_sync[1]);
    s_nxt.sh_in = byte_in[6:0];
    s_nxt.bit_cnt = f.bit_cnt + BIT_ONE;
    s_nxt.sh_out = {f.sh_out[6:0], 1'b0};
    if (f.bit_cnt == BIT_LAST) begin
      case (f.phase)
        PH_CMD: begin
          s_nxt.addr = byte_in[6:0];
          s_nxt.is_rd = byte_in[SPI_RD];
          s_nxt.phase = byte_in[SPI_RD] ? PH_DUMMY : PH_DATA;
          if (byte_in[SPI_RD]) begin
            s_nxt.req = '{wr: 1'b0, addr: byte_in[6:0], wdata: BYTE_ZERO};
            s_nxt.req_tgl = ~f.req_tgl;
          end
        end
        PH_DUMMY, PH_DATA: begin
          s_nxt.addr = next_addr;
          s_nxt.phase = PH_DATA;
          if (f.is_rd) begin
            // answer only taken once the bank has acknowledged it
            s_nxt.sh_out = (f.ack_sync[1] == f.req_tgl) ? rdata : IDLE_BYTE;
            s_nxt.req = '{wr: 1'b0, addr: next_addr, wdata: BYTE_ZERO};
          end else begin
            s_nxt.req = '{wr: 1'b1, addr: f.addr, wdata: byte_in};
          end
          s_nxt.req_tgl = ~f.req_tgl;
        end
        default: s_nxt.phase = PH_CMD;
      endcase
    end
  end

  // link state survives between frames so the toggle stays consistent
  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end

  // marks that the current frame has seen an edge
  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) in_frame_r <= 1'b0;
    else in_frame_r <= 1'b1;
  end

  // read data leaves on the falling edge, released when select rises
  // state left by an earlier frame never drives before this frame's first rising edge
  always_ff @(negedge spi_clk or posedge spi_cs_n or negedge link_rst_n) begin
    if (spi_cs_n || !link_rst_n) begin
      pin_r <= '0;
    end else begin
      pin_r.d <= s_r.sh_out[7];
      pin_r.sdo_en <= in_frame_r && s_r.is_rd && s_r.phase == PH_DATA && !s_r.wire3_sync[1];
      pin_r.sdio_en <= in_frame_r && s_r.is_rd && s_r.phase == PH_DATA && s_r.wire3_sync[1];
    end
  end

  assign req_tgl = s_r.req_tgl;
  assign req = s_r.req;
  assign sdo_drive = pin_r.d;
  assign sdo_drive_en = pin_r.sdo_en;
  assign sdio_drive = pin_r.d;
  assign sdio_drive_en = pin_r.sdio_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_step;
    @(posedge spi_clk) disable iff (spi_cs_n)
    in_frame_r && s_r.bit_cnt == BIT_LAST && s_r.phase != PH_CMD && s_r.step_sync[1]
    |=> s_r.addr == $past(s_r.addr) + ADDR_STEP;
  endproperty
  a_step: assert property (p_step) else $error("burst address did not advance");

  property p_three_wire;
    @(negedge spi_clk) disable iff (spi_cs_n)
    pin_r.sdio_en |-> !pin_r.sdo_en && s_r.wire3_sync[1];
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("shared line driven outside three-wire");

  property p_quiet_start;
    @(posedge spi_clk) disable iff (spi_cs_n)
    !in_frame_r |-> !pin_r.sdo_en && !pin_r.sdio_en;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("data line driven at frame start");

endmodule // imh_spi_link

// ---- src/imh_config_bank.sv ----
// host configuration, status and output register bank of the imu
// How it works
// - raw temperature, acceleration and rate samples are latched unchanged for reading.
// - accelerometer and gyroscope settings live in separate registers, written apart.
// - enable register holds fusion, accelerometer and gyroscope bits, each independent.
// - each sensor register holds full scale, output rate and self test.
// - filter register configures and switches the low-pass filters.
// - status reports new data, fifo ready and command done.
// - timestamp is a 24-bit counter that wraps to zero after all ones.
// - samples pass in the sensor frame and units, with no conversion.
// - each link read request to the fifo register, prefetch requests included, returns one byte and pops it while data is held.
// - identifier register is a read-only fixed byte; writes are ignored.
// - revision register is a read-only fixed byte; writes are ignored.
// - interface bit 7 picks four-wire (0) or three-wire (1) serial.
// - interface bit 6 picks fixed (0) or stepping (1) burst address.
// - interface bit 5 picks little (0) or big (1) endian reads, reset 1.
// - each output is 16-bit two's complement, low then high byte when bit 5 is 0, high then low when it is 1.
module imh_config_bank import imh_pkg::*; #(
  parameter logic [7:0] DEV_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h3c // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic sdio_sense,
  output logic sdio_drive,
  output logic sdio_drive_en,
  output logic sdo_drive,
  output logic sdo_drive_en,
  input wire imh_sample_s sample_in,
  input wire logic sample_valid,
  input wire logic [7:0] fifo_byte,
  input wire logic fifo_has_data,
  output logic fifo_pop,
  input wire logic cmd_done,
  output logic [7:0] cmd_code,
  output logic cmd_strobe,
  output logic [7:0] accel_cfg,
  output logic [7:0] gyro_cfg,
  output logic [7:0] lpf_cfg,
  output logic accel_on,
  output logic gyro_on,
  output logic fusion_engine_on,
  output logic [7:0] wire_mode_cfg
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] req_sync;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [7:0] sif;
    logic [7:0] acc;
    logic [7:0] gyr;
    logic [7:0] lpf;
    logic [7:0] ena;
    logic [7:0] cmd_code;
    logic cmd_strobe;
    logic fifo_pop;
    logic drdy_acc;
    logic drdy_gyr;
    logic done;
    imh_sample_s smp;
    logic [23:0] ts;
  } imh_bank_s;

  localparam imh_bank_s BANK_RST = '{sif: SIF_RST, default: '0};

  imh_bank_s s_r, s_nxt;
  logic [1:0] rst_pipe_r;
  logic rst_n;
  logic link_req_tgl;
  imh_req_s link_req;
  logic hit, rd_hit, wr_hit;
  logic [7:0] rbyte;
  logic [7:0] temp_hi;

  // picks one output byte, swapping within a pair for big endian
  function automatic logic [7:0] out_byte(input imh_sample_s smp, input logic [6:0] a,
                                          input logic be);
    logic [6:0] idx;
    logic [3:0] sel;
    idx = a - A_OUT_LO;
    sel = idx[3:0] ^ {3'h0, be};
    return smp[{sel, 3'h0} +: 8];
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // reset asserts at once and releases after two clean edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rst_pipe_r <= 2'h0;
    else rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_n = rst_pipe_r[1];

  // ---------------------------------------------------------------
  // serial link on its own clock
  // ---------------------------------------------------------------
  imh_spi_link u_link (
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .link_rst_n(rst_n),
    .spi_sdi(spi_sdi),
    .sdio_sense(sdio_sense),
    .wire3(s_r.sif[SIF_WIRE3]),
    .step_en(s_r.sif[SIF_STEP]),
    .ack_tgl(s_r.ack_tgl),
    .rdata(s_r.rdata),
    .req_tgl(link_req_tgl),
    .req(link_req),
    .sdo_drive(sdo_drive),
    .sdo_drive_en(sdo_drive_en),
    .sdio_drive(sdio_drive),
    .sdio_drive_en(sdio_drive_en)
  );

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  // byte returned for the address the link has asked for
  always_comb begin
    rbyte = BYTE_ZERO;
    if (link_req.addr >= A_OUT_LO && link_req.addr <= A_OUT_HI) begin
      rbyte = out_byte(s_r.smp, link_req.addr, s_r.sif[SIF_ORDER]);
    end else begin
      case (link_req.addr)
        A_DEV_ID: rbyte = DEV_ID;
        A_REV: rbyte = REV_ID;
        A_SIF: rbyte = s_r.sif;
        A_ACC: rbyte = s_r.acc;
        A_GYR: rbyte = s_r.gyr;
        A_LPF: rbyte = s_r.lpf;
        A_ENA: rbyte = s_r.ena;
        A_CMD: rbyte = s_r.cmd_code;
        A_FIFO: rbyte = fifo_has_data ? fifo_byte : BYTE_ZERO;
        A_ST_LOCK: begin
          rbyte[LOCK_AVAIL] = s_r.drdy_acc | s_r.drdy_gyr;
          rbyte[LOCK_DONE] = s_r.done;
        end
        A_ST_DRDY: begin
          rbyte[DRDY_ACC] = s_r.drdy_acc;
          rbyte[DRDY_GYR] = s_r.drdy_gyr;
          rbyte[DRDY_FIFO] = fifo_has_data;
        end
        A_ST_MOT: rbyte = BYTE_ZERO;
        A_TS_L: rbyte = s_r.ts[7:0];
        A_TS_M: rbyte = s_r.ts[TS_MID_POS +: 8];
        A_TS_H: rbyte = s_r.ts[TS_HI_POS +: 8];
        default: rbyte = BYTE_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register bank next state
  // ---------------------------------------------------------------
  // request toggle is synchronised, payload is stable once it is seen
  always_comb begin
    s_nxt = s_r;
    s_nxt.req_sync = {s_r.req_sync[0], link_req_tgl};
    s_nxt.cmd_strobe = 1'b0;
    s_nxt.fifo_pop = 1'b0;
    hit = s_r.req_sync[1] != s_r.req_seen;
    rd_hit = hit && !link_req.wr;
    wr_hit = hit && link_req.wr;

    // reads clear status first, so an event in the same cycle wins
    if (rd_hit && link_req.addr == A_ST_DRDY) begin
      s_nxt.drdy_acc = 1'b0;
      s_nxt.drdy_gyr = 1'b0;
    end
    if (rd_hit && link_req.addr == A_ST_LOCK) s_nxt.done = 1'b0;
    if (cmd_done) s_nxt.done = 1'b1;

    // raw samples latched as delivered, per enabled sensor
    if (sample_valid && (s_r.ena[ENA_ACC] || s_r.ena[ENA_GYR])) begin
      s_nxt.smp.temp = sample_in.temp;
      s_nxt.ts = s_r.ts + TS_STEP;
      if (s_r.ena[ENA_ACC]) begin
        s_nxt.smp.ax = sample_in.ax;
        s_nxt.smp.ay = sample_in.ay;
        s_nxt.smp.az = sample_in.az;
        s_nxt.drdy_acc = 1'b1;
      end
      if (s_r.ena[ENA_GYR]) begin
        s_nxt.smp.gx = sample_in.gx;
        s_nxt.smp.gy = sample_in.gy;
        s_nxt.smp.gz = sample_in.gz;
        s_nxt.drdy_gyr = 1'b1;
      end
    end

    // read answer and its side effects
    if (rd_hit) begin
      s_nxt.rdata = rbyte;
      s_nxt.fifo_pop = link_req.addr == A_FIFO && fifo_has_data;
    end

    // writes; identifier, revision and status ignore them
    if (wr_hit) begin
      case (link_req.addr)
        A_SIF: s_nxt.sif = link_req.wdata;
        A_ACC: s_nxt.acc = link_req.wdata;
        A_GYR: s_nxt.gyr = link_req.wdata;
        A_LPF: s_nxt.lpf = link_req.wdata;
        A_ENA: s_nxt.ena = link_req.wdata;
        A_CMD: begin
          s_nxt.cmd_code = link_req.wdata;
          s_nxt.cmd_strobe = 1'b1;
        end
        default: s_nxt.cmd_strobe = 1'b0;
      endcase
    end

    // acknowledge every taken request by toggling back
    if (hit) begin
      s_nxt.req_seen = s_r.req_sync[1];
      s_nxt.ack_tgl = ~s_r.ack_tgl;
    end
  end

  // bank registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) s_r <= BANK_RST;
    else s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // outputs to the sensor core
  // ---------------------------------------------------------------
  assign accel_cfg = s_r.acc;
  assign gyro_cfg = s_r.gyr;
  assign lpf_cfg = s_r.lpf;
  assign accel_on = s_r.ena[ENA_ACC];
  assign gyro_on = s_r.ena[ENA_GYR];
  assign fusion_engine_on = s_r.ena[ENA_FUS];
  assign cmd_code = s_r.cmd_code;
  assign cmd_strobe = s_r.cmd_strobe;
  assign fifo_pop = s_r.fifo_pop;
  assign wire_mode_cfg = s_r.sif;
  assign temp_hi = s_r.smp.temp[15:8];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_dev_id;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit && link_req.addr == A_DEV_ID |=> s_r.rdata == DEV_ID;
  endproperty
  a_dev_id: assert property (p_dev_id) else $error("identifier read wrong");

  property p_rev_id;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit && link_req.addr == A_REV |=> s_r.rdata == REV_ID;
  endproperty
  a_rev_id: assert property (p_rev_id) else $error("revision read wrong");

  property p_wire_mode;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_SIF ##1 !hit |=> wire_mode_cfg == $past(link_req.wdata, 2);
  endproperty
  a_wire_mode: assert property (p_wire_mode) else $error("interface control not stored");

  property p_order;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit && link_req.addr == A_OUT_LO && s_r.sif[SIF_ORDER] && !sample_valid
    |=> s_r.rdata == $past(temp_hi);
  endproperty
  a_order: assert property (p_order) else $error("big endian read gave low byte");

  property p_indep;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_ACC |=> $stable(gyro_cfg) && accel_cfg == $past(link_req.wdata);
  endproperty
  a_indep: assert property (p_indep) else $error("accelerometer write disturbed gyroscope");

  property p_stamp;
    @(posedge ref_clk) disable iff (!rst_n)
    sample_valid && (accel_on || gyro_on) && s_r.ts == TS_MAX |=> s_r.ts == 24'h000000;
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp did not wrap");

  property p_done;
    @(posedge ref_clk) disable iff (!rst_n)
    cmd_done |=> s_r.done ##1 (s_r.done || $past(rd_hit));
  endproperty
  a_done: assert property (p_done) else $error("command done lost");

  property p_pop;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit && link_req.addr == A_FIFO && fifo_has_data |=> fifo_pop && s_r.rdata == $past(fifo_byte);
  endproperty
  a_pop: assert property (p_pop) else $error("fifo read did not pop one byte");

  property p_enable;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_ENA
    |=> accel_on == $past(link_req.wdata[ENA_ACC]) && gyro_on == $past(link_req.wdata[ENA_GYR]);
  endproperty
  a_enable: assert property (p_enable) else $error("sensor enable not applied");

  property p_gyro_indep;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_GYR |=> $stable(accel_cfg) && gyro_cfg == $past(link_req.wdata);
  endproperty
  a_gyro_indep: assert property (p_gyro_indep) else $error("gyroscope write disturbed accelerometer");

  property p_filter;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_LPF |=> lpf_cfg == $past(link_req.wdata);
  endproperty
  a_filter: assert property (p_filter) else $error("filter control not stored");

  property p_ts_step;
    @(posedge ref_clk) disable iff (!rst_n)
    sample_valid && (accel_on || gyro_on) |=> s_r.ts == $past(s_r.ts) + TS_STEP;
  endproperty
  a_ts_step: assert property (p_ts_step) else $error("timestamp did not count the sample");

  property p_latch;
    @(posedge ref_clk) disable iff (!rst_n)
    sample_valid && accel_on |=> s_r.smp.ax == $past(sample_in.ax) && s_r.drdy_acc;
  endproperty
  a_latch: assert property (p_latch) else $error("raw sample not latched");

  property p_drdy_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit && link_req.addr == A_ST_DRDY && !sample_valid |=> !s_r.drdy_acc && !s_r.drdy_gyr;
  endproperty
  a_drdy_clear: assert property (p_drdy_clear) else $error("data ready not cleared by read");

  property p_cmd;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && link_req.addr == A_CMD |=> cmd_strobe && cmd_code == $past(link_req.wdata);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command write not issued");

endmodule // imh_config_bank

// ---- verif/imh_host_model.sv ----
// host serial bus master model driving the imu register bank
module imh_host_model (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_sdi,
  output logic sdio_sense,
  input wire logic sdo_drive,
  input wire logic sdo_drive_en,
  input wire logic sdio_drive,
  input wire logic sdio_drive_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic h_bit;
  logic w3_r;
  // device wins while it drives; the line unused in the current wiring shows the inverse bit
  assign sdio_sense = sdio_drive_en ? sdio_drive : (w3_r ? h_bit : ~h_bit);
  assign spi_sdi = w3_r ? ~h_bit : h_bit;
  // clock stands high and select high outside frames
  initial begin
    spi_clk = 1'b1;
    spi_cs_n = 1'b1;
    h_bit = 1'b0;
    w3_r = 1'b0;
  end
  // one frame: command byte, dummy byte on reads, then nb data bytes msb first
  task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] wd, input int nb,
                       input logic w3, output logic [15:0] q);
    logic [7:0] cmd;
    int i;
    cmd = {rd, a};
    q = 16'h0000;
    w3_r = w3;
    spi_cs_n = 1'b0;
    #40;
    for (i = 0; i < 8 * (nb + 1 + int'(rd)); i++) begin
      spi_clk = 1'b0;
      if (i < 8) h_bit = cmd[7 - i];
      else if (!rd) h_bit = wd[8 * nb + 7 - i];
      else h_bit = ~h_bit; // released line never shows a held value
      #40;
      spi_clk = 1'b1;
      // take read bits only from the line that matches the wiring
      if (rd && i >= 16) q = {q[14:0], w3 ? (sdio_drive_en ? sdio_drive : 1'bx) : (sdo_drive_en ? sdo_drive : 1'bx)};
      #40;
    end
    spi_cs_n = 1'b1;
    #400;
  endtask
endmodule // imh_host_model

// ---- verif/testbench.sv ----
// self-checking testbench for the imu host register bank
module testbench import imh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] DEV = 8'h5a; // arbitrary value
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic spi_clk, spi_cs_n, spi_sdi, sdio_sense, sdio_drive, sdio_drive_en, sdo_drive, sdo_drive_en;
  imh_sample_s sample_in = '{gz: 16'h0707, gy: 16'h0606, gx: 16'h0505, az: 16'h0404, ay: 16'h0303,
                             ax: 16'h1f2e, temp: 16'h8123};
  logic sample_valid = 1'b0;
  logic [7:0] fifo_byte = 8'ha7;
  logic fifo_has_data = 1'b0;
  logic fifo_pop, cmd_strobe, accel_on, gyro_on, fusion_engine_on;
  logic cmd_done = 1'b0;
  logic [7:0] cmd_code, accel_cfg, gyro_cfg, lpf_cfg, wire_mode_cfg;
  logic w3 = 1'b0;
  logic [15:0] q;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int pops = 0;
  int strobes = 0;
  int sdo_en_cnt = 0;

  always #25 ref_clk = ~ref_clk;
  // cycle ceiling and pulse counters, sampled away from the launching edge
  always @(negedge ref_clk) begin
    cyc++;
    if (fifo_pop === 1'b1) pops++;
    if (cmd_strobe === 1'b1) strobes++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  always @(posedge sdo_drive_en) sdo_en_cnt++;

  imh_config_bank #(.DEV_ID(DEV), .REV_ID(REV)) u_imh_config_bank (.ref_clk(ref_clk), .reset_n(reset_n),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .sdio_sense(sdio_sense),
    .sdio_drive(sdio_drive), .sdio_drive_en(sdio_drive_en), .sdo_drive(sdo_drive),
    .sdo_drive_en(sdo_drive_en), .sample_in(sample_in), .sample_valid(sample_valid),
    .fifo_byte(fifo_byte), .fifo_has_data(fifo_has_data), .fifo_pop(fifo_pop), .cmd_done(cmd_done),
    .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .accel_cfg(accel_cfg), .gyro_cfg(gyro_cfg),
    .lpf_cfg(lpf_cfg), .accel_on(accel_on), .gyro_on(gyro_on), .fusion_engine_on(fusion_engine_on),
    .wire_mode_cfg(wire_mode_cfg));

  imh_host_model u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .sdio_sense(sdio_sense), .sdo_drive(sdo_drive), .sdo_drive_en(sdo_drive_en),
    .sdio_drive(sdio_drive), .sdio_drive_en(sdio_drive_en));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] dummy;
    u_host.frame(1'b0, a, {8'h00, d}, 1, w3, dummy);
  endtask
  task automatic rd(input logic [6:0] a, input int nb);
    u_host.frame(1'b1, a, 16'h0000, nb, w3, q);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_ident;
    chk({8'h00, wire_mode_cfg}, 16'h0020);
    rd(A_SIF, 1);
    chk(q, 16'h0020);
    wr(A_DEV_ID, 8'h00);
    wr(A_REV, 8'hff);
    rd(A_DEV_ID, 1);
    chk(q, {8'h00, DEV});
    rd(A_REV, 1);
    chk(q, {8'h00, REV});
  endtask
  task automatic t_cfg;
    wr(A_ACC, 8'hb7);
    chk({accel_cfg, gyro_cfg}, 16'hb700);
    wr(A_GYR, 8'h4a);
    chk({accel_cfg, gyro_cfg}, 16'hb74a);
    wr(A_LPF, 8'h15);
    chk({8'h00, lpf_cfg}, 16'h0015);
  endtask
  task automatic t_ena;
    int b;
    for (b = 0; b < 4; b++) begin
      wr(A_ENA, 8'h01 << b);
      chk({13'h0000, fusion_engine_on, gyro_on, accel_on}, {13'h0000, b == 3, b == 1, b == 0});
    end
  endtask
  task automatic t_sample;
    wr(A_ENA, 8'h01);
    pulse(sample_valid);
    rd(A_ST_DRDY, 1);
    chk(q & 16'h0001, 16'h0001);
    rd(A_ST_DRDY, 1);
    chk(q & 16'h0001, 16'h0000);
    rd(A_TS_L, 1);
    chk(q, 16'h0001);
    rd(A_OUT_LO, 1);
    chk(q, 16'h0081);
    wr(A_SIF, 8'h40);
    rd(A_DEV_ID, 1);
    rd(A_OUT_LO, 2);
    chk(q, 16'h2381);
    rd(7'h35, 2);
    chk(q, 16'h2e1f);
    wr(A_SIF, 8'h00);
    rd(A_DEV_ID, 1);
    rd(A_REV, 2);
    chk(q, {REV, REV});
  endtask
  task automatic t_wire3;
    wr(A_SIF, 8'h80);
    w3 = 1'b1;
    wr(A_DEV_ID, 8'h00);
    sdo_en_cnt = 0;
    rd(A_DEV_ID, 1);
    chk(q, {8'h00, DEV});
    chk(16'(sdo_en_cnt), 16'h0000);
    wr(A_SIF, 8'h20);
    w3 = 1'b0;
    rd(A_DEV_ID, 1);
    rd(A_DEV_ID, 1);
    chk(q, {8'h00, DEV});
  endtask
  task automatic t_fifo_cmd;
    @(negedge ref_clk) fifo_has_data = 1'b1;
    rd(A_ST_DRDY, 1);
    chk(q & 16'h0004, 16'h0004);
    rd(A_FIFO, 1);
    chk(q, 16'h00a7);
    chk(16'(pops > 0), 16'h0001);
    wr(A_CMD, 8'h5c);
    chk({7'h00, strobes == 1, cmd_code}, 16'h015c);
    pulse(cmd_done);
    rd(A_ST_LOCK, 1);
    chk(q & 16'h0080, 16'h0080);
  endtask

  // ---------------------------------------------------------------
  // main sequence and verdict
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_ident();
    t_cfg();
    t_ena();
    t_sample();
    t_wire3();
    t_fifo_cmd();
    conclude();
  end
endmodule // testbench
